// [rtl/channel_volume_trim_regs.sv]
// Channel two volume, gain trim and phase delay configuration registers.
// Functional notes
// R01 - A volume code of zero mutes the channel output completely.
// R02 - Volume code one is -100 dB and code two is -99.5 dB, half a decibel per step.
// R03 - Volume code 201 is 0 dB, code 202 is +0.5 dB and code 255 is +27 dB.
// R04 - The volume register resets to 0xc9 and is readable and writable.
// R05 - The trim field in bits 7 to 4 is 0 dB at code 8, from -0.8 dB at 0 to +0.7 dB at 15.
// R06 - Each trim step adds a tenth of a decibel, so code 9 is +0.1 dB and code 1 is -0.7 dB.
// R07 - The trim field resets to 1000b and the whole trim register reads 0x80.
// R08 - The low four trim bits are read-only and read zero; software writes zeros there.
// R09 - The phase code delays the channel by that many modulator clock cycles, 1 to 255.
// R10 - Phase code zero adds no delay; the phase register resets to zero and is read/write.
// R11 - Intermediate volume and trim codes follow the uniform step sizes.
`timescale 1ns/1ns
`include "chan_two_map.svh"
module channel_volume_trim_regs
   import chan_two_pkg::*;
(
   input  wire logic                    clk,      // Clock, 250 MHz.
   input  wire logic                    rst,      // Synchronous reset, active high.
   input  wire chan_two_pkg::reg_req_t  req,      // Register access from the control port.
   output chan_two_pkg::reg_rsp_t       rsp,      // Read answer, one cycle after request.
   output chan_two_pkg::chan_setting_t  setting   // Decoded settings for the datapath.
);
   import chan_two_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // Entry table: offset and writable bits of each register, entry 0 in the low byte.
   localparam logic [2:0][7:0] entry_offset  =
      {`PHASE_OFFSET, `GAIN_TRIM_OFFSET, `VOLUME_OFFSET};
   localparam logic [2:0][7:0] entry_wr_mask =
      {8'hff, ~`TRIM_RSVD_MASK, 8'hff}; // [R08]

   ////////////////////////////////////////////////////////////////////////////////
   // Volume in tenths of a decibel: code one is the floor, then half a decibel per code.
   function automatic logic signed [15:0] volume_tenths(input logic [7:0] code);
      logic signed [15:0] steps;
      steps = $signed({8'h00, code - 8'h01});
      return `VOLUME_MIN_DB_X10 + 16'(steps * `VOLUME_STEP_X10); // [R02] [R03] [R11]
   endfunction

   // Gain trim in tenths of a decibel, one entry per code, zero at the unity code.
   function automatic logic signed [7:0] trim_tenths(input logic [3:0] code);
      logic signed [7:0] t;
      case (code)
         4'h0:    t = 8'shf8; // [R05]
         4'h1:    t = 8'shf9; // [R06]
         4'h2:    t = 8'shfa;
         4'h3:    t = 8'shfb;
         4'h4:    t = 8'shfc;
         4'h5:    t = 8'shfd;
         4'h6:    t = 8'shfe;
         4'h7:    t = 8'shff;
         4'h8:    t = 8'sh00; // [R05]
         4'h9:    t = 8'sh01; // [R06]
         4'ha:    t = 8'sh02;
         4'hb:    t = 8'sh03;
         4'hc:    t = 8'sh04;
         4'hd:    t = 8'sh05;
         4'he:    t = 8'sh06;
         4'hf:    t = 8'sh07; // [R05]
         default: t = 8'sh00;
      endcase
      return t;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic          rvalid;
      logic          hit;
      chan_setting_t set;
   } state_t;
   state_t s_reg, s_next;

   logic [1:0]  idx;
   logic        mapped;
   logic [7:0]  wdata_masked;
   logic [2:0]  entry_sel;
   logic [2:0][7:0] entry_wdat;
   logic [7:0]  rd_data;
   logic [23:0] cur_all;
   logic [7:0]  vol_code;
   logic [3:0]  trim_code;
   logic [7:0]  phase_code;

   ////////////////////////////////////////////////////////////////////////////////
   // One comparator per entry; the offsets are distinct, so at most one matches.
   for (genvar e = 0; e < 3; e++) begin : g_entry
      assign entry_sel[e]  = (req.addr == entry_offset[e]);
      // Reserved trim bits never store, so they always read back as zero.
      assign entry_wdat[e] = req.wdata & entry_wr_mask[e]; // [R08]
   end

   // Unmapped addresses select entry three, which the store neither writes nor reads.
   always_comb begin
      idx          = 2'h3;
      mapped       = 1'b0;
      wdata_masked = 8'h00;
      for (int e = 0; e < 3; e++) begin
         if (entry_sel[e]) begin
            idx          = 2'(e);
            mapped       = 1'b1;
            wdata_masked = entry_wdat[e];
         end
      end
   end

   chan_two_cfg_store u_store (
      .clk     (clk),
      .rst     (rst),           // [R04] [R07] [R10]
      .wr_idx  (idx),
      .wr_en   (req.wr_en),
      .wr_data (wdata_masked),
      .rd_idx  (idx),
      .rd_data (rd_data),
      .cur_all (cur_all)
   );

   assign vol_code   = cur_all[7:0];
   assign trim_code  = cur_all[8+`TRIM_FIELD_MSB:8+`TRIM_FIELD_LSB];
   assign phase_code = cur_all[23:16];

   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      s_next = s_reg;
      s_next.rvalid = req.rd_en;
      s_next.hit    = mapped;
      s_next.set.mute = (vol_code == `VOLUME_MUTE_CODE); // [R01]
      s_next.set.volume_db_x10 = volume_tenths(vol_code); // [R02] [R03] [R11]
      s_next.set.trim_db_x10   = trim_tenths(trim_code);  // [R05] [R06] [R11]
      s_next.set.phase_cycles = phase_code; // [R09] [R10]
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_reg.rvalid            <= 1'b0;
         s_reg.hit               <= 1'b0;
         s_reg.set.mute          <= 1'b0;
         s_reg.set.volume_db_x10 <= 16'sh0000;
         s_reg.set.trim_db_x10   <= 8'sh00;
         s_reg.set.phase_cycles  <= 8'h00;
      end else begin
         s_reg <= s_next;
      end
   end

   assign rsp.rvalid = s_reg.rvalid;
   assign rsp.hit    = s_reg.hit;
   assign rsp.rdata  = rd_data;
   assign setting    = s_reg.set;
endmodule

// [pkg/chan_two_map.svh]
// Register offsets, field positions, reset values and derived constants for channel two.
`ifndef CHAN_TWO_MAP_SVH
`define CHAN_TWO_MAP_SVH
`define VOLUME_OFFSET      8'h43
`define GAIN_TRIM_OFFSET   8'h44
`define PHASE_OFFSET       8'h45
`define VOLUME_RESET       8'hc9
`define GAIN_TRIM_RESET    8'h80
`define PHASE_RESET        8'h00
`define TRIM_FIELD_MSB     7
`define TRIM_FIELD_LSB     4
`define TRIM_RSVD_MASK     8'h0f
`define VOLUME_MUTE_CODE   8'h00
`define VOLUME_UNITY_CODE  8'hc9
`define TRIM_UNITY_CODE    4'h8
`define VOLUME_MIN_DB_X10  16'shfc18
`define VOLUME_STEP_X10    16'sh0005
`define TRIM_STEP_X10      8'sh01
`endif

// [pkg/chan_two_pkg.sv]
// Types shared by the channel two register bank.
package chan_two_pkg;
   typedef struct packed {
      logic       wr_en;
      logic       rd_en;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;
   typedef struct packed {
      logic       rvalid;
      logic       hit;
      logic [7:0] rdata;
   } reg_rsp_t;
   typedef struct packed {
      logic              mute;
      logic signed [15:0] volume_db_x10;
      logic signed [7:0]  trim_db_x10;
      logic [7:0]        phase_cycles;
   } chan_setting_t;
endpackage

// [rtl/chan_two_cfg_store.sv]
// Three-entry configuration store with registered read data.
`timescale 1ns/1ns
`include "chan_two_map.svh"
module chan_two_cfg_store (
   input  wire logic       clk,      // Clock.
   input  wire logic       rst,      // Synchronous reset.
   input  wire logic [1:0] wr_idx,   // Entry written.
   input  wire logic       wr_en,    // Write strobe.
   input  wire logic [7:0] wr_data,  // Write data.
   input  wire logic [1:0] rd_idx,   // Entry read.
   output logic [7:0]      rd_data,  // Registered read data.
   output logic [23:0]     cur_all   // Current contents, entry 0 low.
);
   typedef struct packed {
      logic [2:0][7:0] mem;
      logic [7:0]      rd;
   } state_t;
   state_t s_reg, s_next;
   always_comb begin
      s_next = s_reg;
      if (wr_en && wr_idx != 2'h3) begin
         s_next.mem[wr_idx] = wr_data;
      end
      s_next.rd = (rd_idx == 2'h3) ? 8'h00 : s_reg.mem[rd_idx];
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         s_reg.mem[0] <= `VOLUME_RESET;
         s_reg.mem[1] <= `GAIN_TRIM_RESET;
         s_reg.mem[2] <= `PHASE_RESET;
         s_reg.rd     <= 8'h00;
      end else begin
         s_reg <= s_next;
      end
   end
   assign rd_data = s_reg.rd;
   assign cur_all = s_reg.mem;
endmodule

// [verif/chan_two_checker.sv]
// Port assertions for the channel two register bank.
`timescale 1ns/1ns
module chan_two_checker
   import chan_two_pkg::*;
(
   input wire logic                        clk,     // Clock.
   input wire logic                        rst,     // Reset.
   input wire chan_two_pkg::reg_req_t      req,     // Request.
   input wire chan_two_pkg::reg_rsp_t      rsp,     // Answer.
   input wire chan_two_pkg::chan_setting_t setting  // Settings.
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   property p_rv; rsp.rvalid == $past(req.rd_en); endproperty
   a_rv: assert property (p_rv) else $error("bad rvalid");
   property p_hit; rsp.hit == ($past(req.addr) inside {[8'h43:8'h45]}); endproperty
   a_hit: assert property (p_hit) else $error("bad hit");
   property p_rsv; req.addr == 8'h44 |=> rsp.rdata[3:0] == 4'h0; endproperty
   a_rsv: assert property (p_rsv) else $error("bad trim low bits");
   property p_mute;
      req.wr_en && req.addr == 8'h43 |-> ##2 setting.mute == ($past(req.wdata, 2) == 8'h00);
   endproperty
   a_mute: assert property (p_mute) else $error("bad mute");
   property p_vol;
      req.wr_en && req.addr == 8'h43 && req.wdata != 8'h00
         |-> ##2 setting.volume_db_x10
             == $signed({8'h00, $past(req.wdata, 2)}) * 16'sd5 - 16'sd1005;
   endproperty
   a_vol: assert property (p_vol) else $error("bad volume");
   property p_trim;
      req.wr_en && req.addr == 8'h44
         |-> ##2 setting.trim_db_x10 == $signed({4'h0, $past(req.wdata[7:4], 2)}) - 8'sd8;
   endproperty
   a_trim: assert property (p_trim) else $error("bad trim");
   property p_ph;
      req.wr_en && req.addr == 8'h45 |-> ##2 setting.phase_cycles == $past(req.wdata, 2);
   endproperty
   a_ph: assert property (p_ph) else $error("bad phase");
   property p_hold; !req.wr_en [*4] |=> $stable(setting); endproperty
   a_hold: assert property (p_hold) else $error("setting moved");
endmodule
bind channel_volume_trim_regs chan_two_checker chk_u (.clk(clk), .rst(rst), .req(req),
   .rsp(rsp), .setting(setting));

// [verif/channel_volume_trim_regs_test.sv]
// Random and corner bench for the channel two register bank.
`timescale 1ns/1ns
module channel_volume_trim_regs_test;
   import chan_two_pkg::*;
   logic          clk = 1'b0;
   logic          rst = 1'b1;
   reg_req_t      req = '0;
   reg_rsp_t      rsp;
   chan_setting_t setting;
   int            err_count = 0, n_checks = 0, cyc = 0, seed = 14603;
   logic [15:0]   rst_val [4] = '{16'hc9, 16'h80, 16'h00, 16'h00};
   channel_volume_trim_regs dut_u (.clk(clk), .rst(rst), .req(req), .rsp(rsp), .setting(setting));
   always #2 clk = ~clk;
   function automatic logic [15:0] vol_db(logic [7:0] c);
      return 16'(c) * 16'd5 - 16'd1005;
   endfunction
   function automatic logic [15:0] trim_db(logic [7:0] c);
      return 16'($signed({4'h0, c[7:4]}) - 8'sd8);
   endfunction
   task automatic check(string what, logic [15:0] want, logic [15:0] got);
      n_checks++;
      if (got !== want) begin
         err_count++;
         $display("MISMATCH %s want=%h got=%h", what, want, got);
      end
   endtask
   task automatic acc(logic wr, logic [7:0] a, logic [7:0] d, output logic [7:0] q);
      @(negedge clk);
      req = '{wr, !wr, a, d};
      @(negedge clk);
      req = '0;
      q = rsp.rdata;
   endtask
   task automatic print_verdict();
      $display("checks=%0d errors=%0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         err_count++;
         print_verdict();
      end
   end
   initial begin
      logic [7:0] q;
      logic [7:0] d;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      for (int i = 0; i < 4; i++) begin
         acc(1'b0, 8'h43 + 8'(i), 8'h00, q);
         check("reset read", rst_val[i], 16'(q));
         check("read hit", 16'(i < 3), 16'(rsp.hit));
         check("read valid", 16'h0001, 16'(rsp.rvalid));
      end
      for (int i = 0; i < 40; i++) begin
         d = (i == 0) ? 8'h00 : (i == 1) ? 8'h01 : (i == 2) ? 8'hff : 8'($random(seed));
         acc(1'b1, 8'h43, d, q);
         acc(1'b1, 8'h44, {d[7:4], 4'h0}, q);
         acc(1'b1, 8'h45, d, q);
         acc(1'b1, 8'h42, ~d, q);
         check("miss hit", 16'h0000, 16'(rsp.hit));
         check("write valid", 16'h0000, 16'(rsp.rvalid));
         repeat (3) @(negedge clk);
         check("mute", 16'(d == 8'h00), 16'(setting.mute));
         if (d != 8'h00) check("volume", vol_db(d), setting.volume_db_x10);
         check("trim", trim_db(d), 16'(setting.trim_db_x10));
         check("phase", 16'(d), 16'(setting.phase_cycles));
         acc(1'b0, 8'h44, 8'h00, q);
         check("trim read", 16'({d[7:4], 4'h0}), 16'(q));
         acc(1'b0, 8'h43, 8'h00, q);
         check("volume read", 16'(d), 16'(q));
      end
      print_verdict();
   end
endmodule
